// ---- sleep_pkg.sv ----
/*
  Shared constants for the SRAM sleep-mode control pair: timing of sleep
  entry and recovery, command encodings and bus widths.
  Assumes a single 50 ns system clock shared by both ends.
*/
package sleep_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // Sleep entry delay after the request is recognised
  localparam int ENTRY_CYCLES = 2;
  // Least recovery time after the request falls, in ns, and in cycles (rounded up)
  localparam int SLEEP_RECOVERY_TIME_NS = 20;
  localparam int RECOVERY_CYCLES_RAW = (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYCLES = (RECOVERY_CYCLES_RAW < 1) ? 1 : RECOVERY_CYCLES_RAW;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 18;
  localparam int DEPTH = 256;
  // Reset values and counter targets
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] RECOVERY_CNT = 4'(RECOVERY_CYCLES);
  localparam logic [1:0] ENTRY_CNT = 2'(ENTRY_CYCLES);
  // Commands on the synchronous bus
  typedef enum logic [1:0] {
    CMD_DESELECT,
    CMD_READ,
    CMD_WRITE,
    CMD_BURST_NEXT
  } cmd_t;
endpackage : sleep_pkg

// ---- sram_bus_if.sv ----
/*
  Interface joining the memory controller and the SRAM model.
  The data bus is two-way: each end gives out, enable and reads the resolved wire.
*/
`timescale 1ns/100ps
interface sram_bus_if
  import sleep_pkg::*;
  (input wire logic clk_sys);
  logic sleep_request;
  logic sleep_request_oe;
  cmd_t cmd;
  logic [ADDR_W-1:0] addr;
  logic oe_n;
  logic [DATA_W-1:0] ctl_dq_out;
  logic ctl_dq_oe;
  logic [DATA_W-1:0] mem_dq_out;
  logic mem_dq_oe;
  logic tck;
  logic tck_oe;
  logic tms;
  logic tdi;
  logic tdo;
  logic asleep;
  // Internal pull-down on the request, pull-up on the test clock when undriven
  wire sleep_level = sleep_request_oe ? sleep_request : 1'b0;
  wire tck_level = tck_oe ? tck : 1'b1;
  wire [DATA_W-1:0] dq = ctl_dq_oe ? ctl_dq_out : (mem_dq_oe ? mem_dq_out : '0);
  modport ctrl (output sleep_request, sleep_request_oe, cmd, addr, oe_n, ctl_dq_out, ctl_dq_oe,
                output tck, tck_oe, tms, tdi, input dq, asleep, clk_sys);
  modport mem (input sleep_level, cmd, addr, oe_n, dq, tck_level, tms, tdi, clk_sys,
               output mem_dq_out, mem_dq_oe, tdo, asleep);
endinterface : sram_bus_if

// ---- sram_sleep_dev.sv ----
/*
  Device end of the sleep-mode pair: a small synchronous SRAM with a burst
  address counter, a power state machine for sleep entry, sleep and
  recovery, and an idle test port.
  Read data is registered and shown on the bus in the cycle after the read
  command, when output enable is low. A read taken with output enable high
  is a dummy read: it moves the burst counter but drives nothing.
  Commands, address, output enable and data come from the controller on
  the same clock and are used as they arrive. The sleep request and the
  test port inputs are treated as pins and pass two flops first.
  Assumes the controller drains its reads before raising the request,
  holds writes back through recovery and places a dummy read between a
  read and a following write.
*/
`timescale 1ns/100ps
module sram_sleep_dev
  import sleep_pkg::*;
  (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // SRAM bus
  sram_bus_if.mem bus,
  // Status
  output logic sleeping,
  output logic recovering
  );
  typedef enum logic [1:0] {
    ST_RUN, // Normal operation
    ST_ENTER, // Request seen, entry delay running
    ST_SLEEP, // Deselected, outputs off
    ST_RECOVER // Request gone, recovery time running
  } pwr_t;

  // Power state and its two counters
  pwr_t state_r;
  pwr_t state_nxt;
  logic [1:0] ent_cnt_r;
  logic [3:0] rec_cnt_r;

  // Storage and the read path
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] rdata_r;
  logic rd_valid_r;

  // Pin synchronisers: request, test clock, test mode and test data
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic sreq_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d_r;

  // Test port
  logic tap_active_r;
  logic tdo_r;

  // Command decode, shared by the read and write paths
  function automatic logic is_read_cmd(input cmd_t c);
    // A burst continuation reads just like a fresh read
    is_read_cmd = (c == CMD_READ) || (c == CMD_BURST_NEXT);
  endfunction : is_read_cmd
  function automatic logic is_write_cmd(input cmd_t c);
    is_write_cmd = (c == CMD_WRITE);
  endfunction : is_write_cmd
  // States in which the bus is listened to
  function automatic logic takes_cmds(input pwr_t s);
    takes_cmds = (s == ST_RUN) || (s == ST_ENTER) || (s == ST_RECOVER);
  endfunction : takes_cmds

  // Raw pin levels; the request pull-down and the test clock pull-up are
  // resolved in the carrier, so either of those two pins reads as its idle level when floating
  wire [3:0] pin_raw = {bus.tdi, bus.tms, bus.tck_level, bus.sleep_level};
  // Every pin passes two flops before logic reads it; no reset is needed,
  // the chain flushes to the pin levels well inside the reset pulse
  always_ff @(posedge clk_sys) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    tck_d_r <= tck_s;
  end
  // Synchronised pin levels
  assign {tdi_s, tms_s, tck_s, sreq_s} = pin_s2_r;

  // Test clock edge; the pull-up keeps it high when unused, so no false edge
  wire tck_rise = tck_s && !tck_d_r;
  // Entry still listens to the bus, since a short request abandons it
  wire accept = takes_cmds(state_r);
  wire do_read = accept && is_read_cmd(bus.cmd);
  wire do_write = accept && (state_r != ST_RECOVER) && is_write_cmd(bus.cmd);
  // Burst continuation takes the last address plus one
  wire [ADDR_W-1:0] next_addr = addr_r + 8'h01;
  wire [ADDR_W-1:0] cur_addr = (bus.cmd == CMD_BURST_NEXT) ? next_addr : bus.addr;
  // Write data is the resolved bus, read data the addressed word
  wire [DATA_W-1:0] wdata = bus.dq;
  wire [DATA_W-1:0] rd_word = mem[cur_addr];
  // State decodes used by the counters and the outputs
  wire in_sleep = (state_r == ST_SLEEP);
  wire in_recover = (state_r == ST_RECOVER);
  wire in_enter = (state_r == ST_ENTER);
  wire entering_sleep = (state_nxt == ST_SLEEP);
  wire entry_done = (ent_cnt_r == ENTRY_CNT - 2'h1);
  wire recovery_done = (rec_cnt_r == RECOVERY_CNT);
  // Counters run only in their own state and restart from zero elsewhere
  wire [1:0] ent_cnt_nxt = in_enter ? ent_cnt_r + 2'h1 : 2'h0;
  wire [3:0] rec_cnt_nxt = in_recover ? rec_cnt_r + 4'h1 : CNT_RST;

  // Power state: entry counted from the synchronised request
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (sreq_s) state_nxt = ST_ENTER;
      end
      ST_ENTER: begin
        if (!sreq_s) state_nxt = ST_RUN;
        else if (entry_done) state_nxt = ST_SLEEP;
      end
      ST_SLEEP: begin
        // Only the request is watched here; every other input is ignored
        if (!sreq_s) state_nxt = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (sreq_s) state_nxt = ST_ENTER;
        else if (recovery_done) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // Power state register
  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= ST_RUN;
    else state_r <= state_nxt;
  end

  // Entry and recovery counters
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ent_cnt_r <= 2'h0;
      rec_cnt_r <= CNT_RST;
    end else begin
      ent_cnt_r <= ent_cnt_nxt;
      rec_cnt_r <= rec_cnt_nxt;
    end
  end

  // Memory array: no reset, so contents survive sleep untouched
  always_ff @(posedge clk_sys) begin
    if (do_write) mem[cur_addr] <= wdata;
  end

  // Burst address: a dummy read moves it exactly like a real read, so the
  // controller's view of the counter never drifts
  always_ff @(posedge clk_sys) begin
    if (rst) addr_r <= ADDR_RST;
    else if (do_read || do_write) addr_r <= cur_addr;
  end

  // Read data register, loaded whether or not the drivers will be enabled
  always_ff @(posedge clk_sys) begin
    if (rst) rdata_r <= DATA_RST;
    else if (do_read) rdata_r <= rd_word;
  end

  // Read answer flag; a read that races into sleep is dropped
  always_ff @(posedge clk_sys) begin
    if (rst) rd_valid_r <= 1'b0;
    else rd_valid_r <= do_read && !entering_sleep;
  end

  // Test port: reset at power-up, wakes only on a real test clock edge with
  // the mode input low, so a floating or tied-off port never leaves reset
  always_ff @(posedge clk_sys) begin
    if (rst) tap_active_r <= 1'b0;
    else if (tck_rise && !tms_s) tap_active_r <= 1'b1;
  end

  // Test output: held low while the port sits in reset
  always_ff @(posedge clk_sys) begin
    if (rst) tdo_r <= 1'b0;
    else tdo_r <= tap_active_r && tdi_s;
  end

  // Outputs off while asleep; output enable high turns a read into a dummy
  assign bus.mem_dq_out = rdata_r;
  assign bus.mem_dq_oe = rd_valid_r && !bus.oe_n && !in_sleep;
  assign bus.tdo = tdo_r;
  assign bus.asleep = in_sleep;

  // Status for the system side
  assign sleeping = in_sleep;
  assign recovering = in_recover;
endmodule : sram_sleep_dev

// ---- sram_sleep_ctrl.sv ----
/*
  Controller end: issues reads and writes, drains before sleep, holds
  writes through recovery and uses a dummy read before a write that follows a read.
  Assumes the device samples commands on clk_sys.
*/
`timescale 1ns/100ps
module sram_sleep_ctrl
  import sleep_pkg::*;
  (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // User side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic sleep_want,
  output logic sleep_granted,
  // SRAM bus
  sram_bus_if.ctrl bus
  );
  logic sreq_r, last_read_r, rd_pend_r, rd_pend2_r;
  logic [3:0] rec_r;
  logic [DATA_W-1:0] rd_data_r;
  // Sleep only once nothing is pending writes wait out recovery
  wire idle = !rd_pend_r && !rd_pend2_r;
  wire in_rec = (rec_r != CNT_RST);
  wire need_dummy = req_valid && req_write && last_read_r;
  wire issue = req_valid && !sreq_r && !sleep_want && !(req_write && in_rec) && !need_dummy;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sreq_r <= 1'b0;
      rec_r <= CNT_RST;
      last_read_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_pend2_r <= 1'b0;
      rd_data_r <= DATA_RST;
    end else begin
      if (sleep_want && idle) sreq_r <= 1'b1;
      else if (!sleep_want) sreq_r <= 1'b0;
      // The device sees the fall three edges late and then recovers for
      // RECOVERY_CNT + 1 edges, so writes wait out both
      if (sreq_r && !sleep_want) rec_r <= RECOVERY_CNT + 4'h4;
      else if (in_rec) rec_r <= rec_r - 4'h1;
      if (need_dummy && !sreq_r) last_read_r <= 1'b0;
      else if (issue) last_read_r <= !req_write;
      rd_pend_r <= issue && !req_write;
      rd_pend2_r <= rd_pend_r;
      // Read data stands on the bus in the cycle after the command
      if (rd_pend_r) rd_data_r <= bus.dq;
    end
  end
  // Dummy read: read command with output enable held off
  assign bus.cmd = issue ? (req_write ? CMD_WRITE : CMD_READ) : (need_dummy && !sreq_r ? CMD_READ : CMD_DESELECT);
  assign bus.addr = req_addr;
  assign bus.oe_n = !(rd_pend_r || (issue && !req_write));
  assign bus.ctl_dq_out = req_wdata;
  assign bus.ctl_dq_oe = issue && req_write;
  assign bus.sleep_request = sreq_r;
  assign bus.sleep_request_oe = 1'b1;
  assign bus.tck = 1'b0;
  assign bus.tck_oe = 1'b0;
  assign bus.tms = 1'b1;
  assign bus.tdi = 1'b1;
  assign req_ready = issue;
  assign rd_data = rd_data_r;
  assign rd_valid = 1'b0 | rd_pend2_r;
  assign sleep_granted = sreq_r && bus.asleep;
endmodule : sram_sleep_ctrl

// ---- sleep_checker.sv ----
/* Checker on the SRAM sleep bus, fed with the interface signals.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module sleep_checker
  import sleep_pkg::*;
  (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus signals
  input wire logic sleep_level,
  input wire cmd_t cmd,
  input wire logic oe_n,
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe,
  input wire logic tdo,
  input wire logic asleep
  );
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Entry waits out the synchroniser, so a fresh request never sleeps at once
  entry_min_a: assert property ($rose(sleep_level) && !asleep |=> !asleep)
    else $error("sleep entered too early");
  entry_bound_a: assert property (sleep_level [*6] |-> asleep)
    else $error("sleep not entered");
  sleep_quiet_a: assert property (asleep |-> !mem_dq_oe)
    else $error("data driven while asleep");
  wake_bound_a: assert property (!sleep_level [*6] |-> !asleep)
    else $error("no wake after request fell");
  recover_write_a: assert property ($fell(sleep_level) |-> (cmd != CMD_WRITE) [*5])
    else $error("write during recovery");
  read_answer_a: assert property ((!sleep_level [*3] ##0 (cmd == CMD_READ && !asleep)) ##1 !oe_n |-> mem_dq_oe)
    else $error("read data missing");
  no_contend_a: assert property (!(mem_dq_oe && ctl_dq_oe))
    else $error("bus contention");
  abort_entry_a: assert property ((($rose(sleep_level) && !asleep) ##1 !sleep_level) |=> !asleep [*6])
    else $error("short request slept");
  test_idle_a: assert property (tdo == 1'b0)
    else $error("test port active");
  // Main scenarios reached
  cover property ($rose(asleep));
  cover property ($fell(asleep));
  cover property (cmd == CMD_READ && oe_n);
endmodule : sleep_checker

// ---- sram_sleep_mode_control_tb.sv ----
/* Testbench joining controller and SRAM ends over the shared bus.
   Assumes the package timing and the controller's sleep handshake. */
`timescale 1ns/100ps
module sram_sleep_mode_control_tb import sleep_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 8'h00;
  logic [DATA_W-1:0] req_wdata = 18'h00000;
  logic sleep_want = 1'b0;
  logic req_ready, rd_valid, sleeping;
  logic recovering, sleep_granted;
  logic seen = 1'b0;
  logic [DATA_W-1:0] rd_data;
  int miscompares = 0;
  int total_checks = 0;
  sram_bus_if bus_if (.clk_sys(clk_sys));
  sram_sleep_dev sram_sleep_dev_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.mem), .sleeping(sleeping),
    .recovering(recovering));
  sram_sleep_ctrl sram_sleep_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .sleep_want(sleep_want), .sleep_granted(sleep_granted),
    .bus(bus_if.ctrl));
  sleep_checker sleep_checker_inst (.clk_sys(clk_sys), .rst(rst), .sleep_level(bus_if.sleep_level),
    .cmd(bus_if.cmd), .oe_n(bus_if.oe_n), .ctl_dq_oe(bus_if.ctl_dq_oe), .mem_dq_oe(bus_if.mem_dq_oe),
    .tdo(bus_if.tdo), .asleep(bus_if.asleep));
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Request held until the controller takes it; an idle edge separates requests
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask : access
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    access(1'b0, a, 18'h00000);
    do begin
      @(negedge clk_sys);
      n++;
    end while (rd_valid !== 1'b1 && n < 20);
    chk(rd_data, exp);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // Watchdog: the tests need under two hundred cycles, so 2000 means a hang
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Writes following reads need a dummy read in between
    access(1'b1, 8'h3c, 18'h2a5a5);
    rd(8'h3c, 18'h2a5a5);
    access(1'b1, 8'hff, 18'h3ffff);
    rd(8'hff, 18'h3ffff);
    $display("test rw done");
    // Long request, then a write straight after waking
    @(posedge clk_sys);
    sleep_want <= 1'b1;
    repeat (12) @(negedge clk_sys);
    chk(18'(sleeping), 18'h00001);
    chk(18'(sleep_granted), 18'h00001);
    chk(18'(bus_if.mem_dq_oe), 18'h00000);
    @(posedge clk_sys);
    sleep_want <= 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(18'(recovering), 18'h00001);
    access(1'b1, 8'h3c, 18'h15a5a);
    rd(8'hff, 18'h3ffff);
    rd(8'h3c, 18'h15a5a);
    $display("test sleep done");
    // One-cycle request must not put the memory to sleep
    @(posedge clk_sys);
    sleep_want <= 1'b1;
    @(posedge clk_sys);
    sleep_want <= 1'b0;
    repeat (10) begin
      @(negedge clk_sys);
      seen = seen | sleeping | recovering;
    end
    chk(18'(seen), 18'h00000);
    rd(8'h3c, 18'h15a5a);
    chk(18'(bus_if.tdo), 18'h00000);
    $display("test abort done");
    end_of_test();
  end
endmodule : sram_sleep_mode_control_tb
